// ==== pkg/lmr_consts.vh ====
`ifndef LMR_CONSTS_VH
`define LMR_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LMR_ADDR_CONTROL 9'h018
`define LMR_ADDR_STATUS 9'h019
`define LMR_BUF_LO 9'h0de
`define LMR_BUF_HI 9'h135
`define LMR_BUF_DEPTH 88

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define LMR_CTL_PENDING 0
`define LMR_CTL_IRQ_EN 1
`define LMR_CTL_ENABLE 2
`define LMR_RST_ENABLE 1'b0
`define LMR_RST_IRQ_EN 1'b0

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define LMR_ST_FLAG 0
`define LMR_ST_COMPLETE 1
`define LMR_ST_FCS_ERR 2
`define LMR_ST_CR 3
`define LMR_ST_KIND_LO 4
`define LMR_ST_ABORT 6

// ----------------------------------------------------------------------
// Link framing constants
// ----------------------------------------------------------------------
`define LMR_DL_SUBFRAME 3'd5
`define LMR_FLAG 8'h7e
`define LMR_TYPE_TEST 8'h32
`define LMR_TYPE_IDLE 8'h34
`define LMR_TYPE_PATH 8'h38
`define LMR_TYPE_ITU 8'h3f
`define LMR_KIND_TEST 2'h0
`define LMR_KIND_IDLE 2'h1
`define LMR_KIND_PATH 2'h2
`define LMR_KIND_ITU 2'h3
`define LMR_HDR_BYTES 8'h03
`define LMR_HOLD_BYTES 8'h05
`define LMR_CRC_INIT 16'hffff
`define LMR_CRC_POLY 16'h8408
`define LMR_CRC_GOOD 16'hf0b8

`endif

// ==== verilog/lmr_rx.v ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "lmr_consts.vh"

// What this block does
// - Serial input is taken only from the three DL bits of F-frame 5.
// - Payload bytes go into the buffer at 0xDE through 0x135 inclusive.
// - Stored payload equals the unstuffed user data.
// - A zero after five ones inside a frame body is dropped.
// - Once enabled, hunt for 0x7E flags that open and close frames.
// - Check word is CRC-16 with x^16+x^12+x^5+1, recomputed here.
// - Nothing is received until software sets the enable bit 2.
// - A detected flag octet sets status bit 0.
// - Status bit 0 clears on the first octet that is not a flag.
// - Seven or more ones after a flag set abort status bit 6.
// - Status bit 3 mirrors the C/R bit of the first address octet.
// - Status bits 5:4 give the message kind from the type byte.
// - The closing flag of a frame sets status bit 1.
// - Frame completion interrupts only when the message differs.
// - Computed and received check words are compared; mismatch sets bit 2.
// - A check word mismatch never raises an interrupt.
module lmr_rx (
  input wire clk_sys_i,
  input wire srst_i,
  input wire ovh_valid_i,
  input wire ovh_bit_i,
  input wire ovh_is_dl_i,
  input wire [2:0] ovh_subframe_i,
  input wire [8:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg irq_o
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [1:0] ST_HUNT = 2'd0;
  localparam [1:0] ST_FLAG = 2'd1;
  localparam [1:0] ST_BODY = 2'd2;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [7:0] msg_ram [0:`LMR_BUF_DEPTH-1];
  reg rx_link_msg_enable;
  reg rx_link_msg_irq_enable;
  reg rx_link_msg_irq_pending;
  reg flag_present;
  reg frame_complete;
  reg check_word_error;
  reg origin_command_response;
  reg [1:0] message_kind;
  reg abort_seen;
  reg [1:0] state;
  reg [7:0] raw_win;
  reg [3:0] win_cnt;
  reg [2:0] raw_ones;
  reg [2:0] data_ones;
  reg [7:0] data_sh;
  reg [3:0] bit_cnt;
  reg [7:0] byte_cnt;
  reg [7:0] hold1;
  reg [7:0] hold2;
  reg [15:0] crc;
  reg differs;
  reg [7:0] prev_len;

  wire dl_bit_en;
  wire [7:0] next_win;
  wire is_flag;
  wire is_abort;
  wire drop_bit;
  wire data_en;
  wire stuffed;
  wire byte_done;
  wire [7:0] next_byte;
  wire [7:0] wr_idx;
  wire wr_en;
  wire frame_ok;
  wire [8:0] rd_idx;
  wire rd_in_buf;
  wire ctl_rd;
  wire complete_evt;
  wire [7:0] ctl_val;
  wire [7:0] status_val;
  wire [15:0] next_crc;

  // --------------------------------------------------------------------
  // Bit extraction and flag/abort detection
  // --------------------------------------------------------------------
  // The framer logic sits on this clock, so its strobes need no synchroniser.
  assign dl_bit_en = rx_link_msg_enable & ovh_valid_i & ovh_is_dl_i &
                     (ovh_subframe_i == `LMR_DL_SUBFRAME);
  assign next_win = {ovh_bit_i, raw_win[7:1]};
  assign is_flag = dl_bit_en & (next_win == `LMR_FLAG);
  assign is_abort = dl_bit_en & ovh_bit_i & (raw_ones == 3'd6);

  // Data lags the raw stream by seven bits: the last body bit leaves as the
  // closing flag's seventh bit arrives, and the flag's first bit would only
  // be due on the edge that recognises the flag, where data is held off.
  assign drop_bit = raw_win[1];
  assign data_en = dl_bit_en & ~is_flag & ~is_abort & (win_cnt == 4'd7) &
                   (state != ST_HUNT);
  assign stuffed = (data_ones == 3'd5) & ~drop_bit;
  assign next_byte = {drop_bit, data_sh[7:1]};
  assign byte_done = data_en & ~stuffed & (bit_cnt == 4'd7);
  assign next_crc = (crc >> 1) ^
                    ((crc[0] ^ drop_bit) ? `LMR_CRC_POLY : 16'h0000);

  // --------------------------------------------------------------------
  // Payload write path
  // --------------------------------------------------------------------
  // Two bytes are held back so the trailing check word is never stored.
  assign wr_idx = byte_cnt - `LMR_HOLD_BYTES;
  assign wr_en = byte_done & (state == ST_BODY) &
                 (byte_cnt >= `LMR_HOLD_BYTES) &
                 (wr_idx < `LMR_BUF_DEPTH);

  assign frame_ok = (state == ST_BODY) & (bit_cnt == 4'd0) &
                    (byte_cnt >= `LMR_HOLD_BYTES);
  assign complete_evt = is_flag & frame_ok;

  // --------------------------------------------------------------------
  // Register read path
  // --------------------------------------------------------------------
  assign rd_idx = reg_addr_i - `LMR_BUF_LO;
  assign rd_in_buf = (reg_addr_i >= `LMR_BUF_LO) &
                     (reg_addr_i <= `LMR_BUF_HI);
  assign ctl_rd = reg_rd_i & (reg_addr_i == `LMR_ADDR_CONTROL);
  assign ctl_val = {5'h00, rx_link_msg_enable, rx_link_msg_irq_enable,
                    rx_link_msg_irq_pending};
  assign status_val = {1'b0, abort_seen, message_kind,
                       origin_command_response, check_word_error,
                       frame_complete, flag_present};

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `LMR_ADDR_CONTROL) begin
        reg_rdata_o <= ctl_val;
      end else if (reg_addr_i == `LMR_ADDR_STATUS) begin
        reg_rdata_o <= status_val;
      end else if (rd_in_buf) begin
        reg_rdata_o <= msg_ram[rd_idx[6:0]];
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Control register and interrupt
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_link_msg_enable <= `LMR_RST_ENABLE;
      rx_link_msg_irq_enable <= `LMR_RST_IRQ_EN;
      rx_link_msg_irq_pending <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `LMR_ADDR_CONTROL) begin
        rx_link_msg_enable <= reg_wdata_i[`LMR_CTL_ENABLE];
        rx_link_msg_irq_enable <= reg_wdata_i[`LMR_CTL_IRQ_EN];
      end
      // A new event in the reading cycle wins over the clear.
      if (complete_evt && !check_word_error_next(crc) &&
          (differs || prev_len != byte_cnt)) begin
        rx_link_msg_irq_pending <= 1'b1;
      end else if (ctl_rd) begin
        rx_link_msg_irq_pending <= 1'b0;
      end
      irq_o <= rx_link_msg_irq_pending & rx_link_msg_irq_enable;
    end
  end

  function check_word_error_next;
    input [15:0] c;
    begin
      check_word_error_next = (c != `LMR_CRC_GOOD);
    end
  endfunction

  // --------------------------------------------------------------------
  // Buffer
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (wr_en) begin
      msg_ram[wr_idx[6:0]] <= hold2;
    end
  end

  // --------------------------------------------------------------------
  // Receive state machine
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= ST_HUNT;
      raw_win <= 8'h00;
      win_cnt <= 4'd0;
      raw_ones <= 3'd0;
      data_ones <= 3'd0;
      data_sh <= 8'h00;
      bit_cnt <= 4'd0;
      byte_cnt <= 8'h00;
      hold1 <= 8'h00;
      hold2 <= 8'h00;
      crc <= `LMR_CRC_INIT;
      differs <= 1'b0;
      prev_len <= 8'h00;
      flag_present <= 1'b0;
      frame_complete <= 1'b0;
      check_word_error <= 1'b0;
      origin_command_response <= 1'b0;
      message_kind <= `LMR_KIND_TEST;
      abort_seen <= 1'b0;
    end else if (!rx_link_msg_enable) begin
      state <= ST_HUNT;
      win_cnt <= 4'd0;
      raw_ones <= 3'd0;
    end else if (dl_bit_en) begin
      raw_win <= next_win;
      if (ovh_bit_i) begin
        if (raw_ones != 3'd7) begin
          raw_ones <= raw_ones + 3'd1;
        end
      end else begin
        raw_ones <= 3'd0;
      end
      if (is_flag) begin
        flag_present <= 1'b1;
        if (complete_evt) begin
          frame_complete <= 1'b1;
          check_word_error <= check_word_error_next(crc);
          prev_len <= byte_cnt;
        end
        state <= ST_FLAG;
        win_cnt <= 4'd0;
        data_ones <= 3'd0;
        bit_cnt <= 4'd0;
        byte_cnt <= 8'h00;
        crc <= `LMR_CRC_INIT;
        differs <= 1'b0;
      end else if (is_abort) begin
        if (state != ST_HUNT) begin
          abort_seen <= 1'b1;
          flag_present <= 1'b0;
        end
        state <= ST_HUNT;
        win_cnt <= 4'd0;
      end else begin
        if (win_cnt != 4'd7) begin
          win_cnt <= win_cnt + 4'd1;
        end
        if (data_en) begin
          if (stuffed) begin
            data_ones <= 3'd0;
          end else begin
            data_sh <= next_byte;
            crc <= next_crc;
            data_ones <= drop_bit ? data_ones + 3'd1 : 3'd0;
            bit_cnt <= (bit_cnt == 4'd7) ? 4'd0 : bit_cnt + 4'd1;
          end
        end
        if (byte_done) begin
          flag_present <= 1'b0;
          hold1 <= next_byte;
          hold2 <= hold1;
          if (byte_cnt != 8'hff) begin
            byte_cnt <= byte_cnt + 8'h01;
          end
          if (state == ST_FLAG) begin
            state <= ST_BODY;
            frame_complete <= 1'b0;
            abort_seen <= 1'b0;
            origin_command_response <= next_byte[1];
          end
          if (byte_cnt == `LMR_HDR_BYTES) begin
            case (next_byte)
              `LMR_TYPE_TEST: message_kind <= `LMR_KIND_TEST;
              `LMR_TYPE_IDLE: message_kind <= `LMR_KIND_IDLE;
              `LMR_TYPE_PATH: message_kind <= `LMR_KIND_PATH;
              `LMR_TYPE_ITU: message_kind <= `LMR_KIND_ITU;
              default: message_kind <= message_kind;
            endcase
          end
          if (wr_en && msg_ram[wr_idx[6:0]] != hold2) begin
            differs <= 1'b1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb/lmr_rx_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module lmr_rx_monitor (
  input wire clk_sys_i,
  input wire srst_i,
  input wire ovh_valid_i,
  input wire [8:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire irq_o
);
  logic [1:0] ctl_q;
  wire rd_ctl = reg_rd_i && reg_addr_i == 9'h018;
  wire rd_map = reg_addr_i == 9'h018 || reg_addr_i == 9'h019 ||
    (reg_addr_i >= 9'h0de && reg_addr_i <= 9'h135);
  // Shadow of the two writable control bits, rebuilt from bus writes.
  always @(posedge clk_sys_i) begin
    if (srst_i)
      ctl_q <= 2'b00;
    else if (reg_wr_i && reg_addr_i == 9'h018)
      ctl_q <= reg_wdata_i[2:1];
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (reg_rd_i && !rd_map |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_ctrl_readback: assert property (rd_ctl |=> reg_rdata_o[7:1] ==
    {5'h00, $past(ctl_q)}) else $error("control readback wrong");
  a_status_top: assert property (reg_rd_i && reg_addr_i == 9'h019 |=>
    !reg_rdata_o[7]) else $error("status bit 7 set");
  a_irq_gated: assert property (irq_o |-> $past(ctl_q[0]))
    else $error("interrupt while disabled");
  a_irq_mirror: assert property (rd_ctl |=>
    irq_o == (reg_rdata_o[0] && reg_rdata_o[1])) else $error("irq mismatch");
  a_irq_clear: assert property (rd_ctl && !ovh_valid_i |=> ##1 !irq_o)
    else $error("interrupt not cleared by read");
  a_reset_quiet: assert property ($fell(srst_i) |-> !irq_o &&
    reg_rdata_o == 8'h00) else $error("outputs busy after reset");
endmodule
`default_nettype wire

// ==== tb/lmr_far_end.sv ====
`timescale 1ns/1ns
`default_nettype none
module lmr_far_end (
  input wire clk_sys_i,
  output logic ovh_valid_o,
  output logic ovh_bit_o,
  output logic ovh_is_dl_o,
  output logic [2:0] ovh_subframe_o
);
  logic [7:0] pl [0:87];
  int ones;
  initial begin
    ovh_valid_o = 1'b0;
    ovh_bit_o = 1'b0;
    ovh_is_dl_o = 1'b0;
    ovh_subframe_o = 3'd4;
    ones = 0;
    foreach (pl[i]) pl[i] = 8'h00;
  end
  // Decoy slots carry the inverted bit, so a receiver that takes them fails.
  task automatic put(input logic b);
    @(posedge clk_sys_i);
    ovh_valid_o <= 1'b1;
    ovh_bit_o <= ~b;
    ovh_subframe_o <= 3'd5;
    ovh_is_dl_o <= 1'b0;
    @(posedge clk_sys_i);
    ovh_bit_o <= b;
    ovh_is_dl_o <= 1'b1;
    @(posedge clk_sys_i);
    ovh_subframe_o <= 3'd4;
    ovh_bit_o <= ~b;
  endtask
  task automatic sb(input logic [7:0] v, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      put(v[i]);
      ones = (stuff && v[i]) ? ones + 1 : 0;
      if (ones == 5) begin
        put(1'b0);
        ones = 0;
      end
    end
  endtask
  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  task automatic send_frame(input logic [7:0] a1, input int n,
                            input logic bad);
    logic [7:0] f [$];
    logic [15:0] c;
    f = {a1, 8'h01, 8'h03};
    for (int i = 0; i < n; i++)
      f.push_back(pl[i]);
    c = 16'hffff;
    foreach (f[i])
      c = crc_upd(c, f[i]);
    c = ~c ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    sb(8'h7e, 1'b0);
    foreach (f[i])
      sb(f[i], 1'b1);
    sb(8'h7e, 1'b0);
    @(posedge clk_sys_i);
    ovh_valid_o <= 1'b0;
  endtask
  task automatic send_abort();
    sb(8'h7e, 1'b0);
    repeat (8) put(1'b1);
    @(posedge clk_sys_i);
    ovh_valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lmr_consts.vh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  err_total++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [8:0] reg_addr_i = 9'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic irq_o;
  logic ovh_valid_i;
  logic ovh_bit_i;
  logic ovh_is_dl_i;
  logic [2:0] ovh_subframe_i;
  logic [7:0] ty [4] = '{8'h32, 8'h34, 8'h38, 8'h3f};
  int err_total = 0;
  int checks_done = 0;
  lmr_rx lmr_rx_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .ovh_valid_i(ovh_valid_i), .ovh_bit_i(ovh_bit_i),
    .ovh_is_dl_i(ovh_is_dl_i), .ovh_subframe_i(ovh_subframe_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  lmr_far_end lmr_far_end_i (.clk_sys_i(clk_sys_i), .ovh_valid_o(ovh_valid_i),
    .ovh_bit_o(ovh_bit_i), .ovh_is_dl_o(ovh_is_dl_i),
    .ovh_subframe_o(ovh_subframe_i));
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("read data", e, reg_rdata_o)
  endtask
  function automatic logic [7:0] st(input logic [7:0] t, a, input logic b);
    logic [1:0] k;
    k = (t == 8'h32) ? 2'h0 : (t == 8'h34) ? 2'h1 :
        (t == 8'h38) ? 2'h2 : 2'h3;
    return {2'b00, k, a[1], b, 2'b11};
  endfunction
  task automatic run(input logic [7:0] t, a, input logic bad, fresh, ie);
    int n;
    n = (t == `LMR_TYPE_ITU) ? 82 : 76;
    if (fresh) begin
      for (int i = 1; i < n; i++) lmr_far_end_i.pl[i] = 8'($urandom);
      lmr_far_end_i.pl[1] = 8'hff;
      lmr_far_end_i.pl[2] = `LMR_FLAG;
    end
    lmr_far_end_i.pl[0] = t;
    lmr_far_end_i.send_frame(a, n, bad);
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("irq", ie, irq_o)
    rd(`LMR_ADDR_STATUS, st(t, a, bad));
    rd(`LMR_ADDR_CONTROL, {5'h00, 2'b11, ie});
    @(posedge clk_sys_i);
    #1;
    `CHK("irq", 1'b0, irq_o)
    for (int i = 0; i < n; i++)
      rd(`LMR_BUF_LO + 9'(i), lmr_far_end_i.pl[i]);
  endtask
  initial begin
    void'($urandom(94));
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(`LMR_ADDR_CONTROL, 8'h00);
    wr(`LMR_ADDR_STATUS, 8'hff);
    rd(`LMR_ADDR_STATUS, 8'h00);
    rd(9'h01a, 8'h00);
    lmr_far_end_i.send_frame(8'h3c, 76, 1'b0);
    rd(`LMR_ADDR_STATUS, 8'h00);
    wr(`LMR_ADDR_CONTROL, 8'h06);
    rd(`LMR_ADDR_CONTROL, 8'h06);
    for (int k = 0; k < 4; k++)
      run(ty[k], k[0] ? 8'h3e : 8'h3c, 1'b0, 1'b1, 1'b1);
    run(ty[3], 8'h3e, 1'b0, 1'b0, 1'b0);
    run(ty[2], 8'h3c, 1'b1, 1'b1, 1'b0);
    lmr_far_end_i.send_abort();
    rd(`LMR_ADDR_STATUS, (st(ty[2], 8'h3c, 1'b1) & 8'hfe) | 8'h40);
    print_verdict();
  end
endmodule
bind lmr_rx lmr_rx_monitor lmr_rx_monitor_i (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .ovh_valid_i(ovh_valid_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
`default_nettype wire
